// *** design/otprc_host.sv ***
// How it works
// - Reset returns array read; we flag lost region mode so software reissues.
// - No fast programming or bypass; full four-cycle program always used.
// - Entry: AA at base+555, 55 at base+2AA, 88 at base+555.
// - Exit: AA at base+555, 55 at base+2AA, 90 at base+555; three writes.
// - Program: AA, 55, A0 unlock writes then one address and data write.
// - After locking, software issues exit so first sector reaches the array.
`timescale 1ns/1ns
`default_nettype none
module otprc_host #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16,
	parameter logic [ADDR_W-1:0] FIRST_SECTOR_WORDS = ADDR_W'(32'h0000_8000),
	parameter logic [11:0] POLL_MAX = 12'hFFF
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	output logic FL_CE_N,
	output logic FL_OE_N,
	output logic FL_WE_N,
	output logic FL_RESET_N,
	output logic FL_FAST_PROGRAM_MODE,
	output logic [ADDR_W-1:0] FL_ADDR,
	output logic [DATA_W-1:0] FL_DQ_OUT,
	output logic FL_DQ_OE,
	input wire logic [DATA_W-1:0] FL_DQ_IN
);
	import otprc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	otprc_state_t state_reg, state_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [3:0] op_reg, op_next;
	logic [1:0] step_reg, step_next;
	logic [ADDR_W-1:0] addr_reg, base_reg;
	logic [DATA_W-1:0] wdata_reg, rdata_reg, rdata_next, prev_reg, prev_next;
	logic region_reg, region_next;
	logic lost_reg, lost_next, refused_reg, refused_next, timeout_reg, timeout_next;
	logic polling_reg, polling_next, first_reg, first_next;
	logic [11:0] poll_cnt_reg, poll_cnt_next;
	logic customer_locked_reg;
	logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
	logic rst_n_reg, rst_n_next, dq_oe_reg, dq_oe_next;
	logic [ADDR_W-1:0] fl_addr_reg, fl_addr_next;
	logic [DATA_W-1:0] fl_dq_reg, fl_dq_next;
	logic [31:0] reg_rdata_reg;
	logic [DATA_W-1:0] dq_sync;

	// Data pins cross into this clock domain here
	otprc_sync #(.W(DATA_W)) u_sync (.MCLK(MCLK), .RST_N(RST_N), .D_IN(FL_DQ_IN), .Q(dq_sync));

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire idle = (state_reg == S_IDLE);
	wire wr_cmd = REG_WR && (REG_ADDR == REG_CMD);
	wire [3:0] cmd_code = REG_WDATA[3:0];
	wire cmd_go = wr_cmd && idle; // Commands while busy are ignored and do not set the refused flag
	wire cnt_done = (cnt_reg == 16'h0000);
	wire [ADDR_W-1:0] region_end = ADDR_W'(REGION_WORDS);
	// Region-mode addresses in the first sector but past the region hold no valid data
	wire gap_addr = region_reg && (addr_reg >= region_end)
		&& (addr_reg < FIRST_SECTOR_WORDS);
	wire factory_addr = region_reg && (addr_reg < ADDR_W'(CUSTOMER_FIRST));
	wire customer_addr = region_reg && !factory_addr && (addr_reg < region_end);
	wire prog_refuse = factory_addr || gap_addr || (customer_addr && customer_locked_reg);
	wire cmd_known = (cmd_code >= CMD_ENTER) && (cmd_code <= CMD_RESET);
	wire refuse = !cmd_known || ((cmd_code == CMD_PROGRAM) && prog_refuse)
		|| ((cmd_code == CMD_READ) && gap_addr);
	wire [1:0] last_step = (op_reg == CMD_PROGRAM) ? 2'd3 : 2'd2;
	wire toggle_same = (dq_sync[TOGGLE_BIT] == prev_reg[TOGGLE_BIT]);
	wire poll_expire = polling_reg && (poll_cnt_reg == POLL_MAX) && !(!first_reg && toggle_same)
		&& (state_reg == S_RD_ACC) && cnt_done;

	// Unlock cycle address and data per step
	wire [ADDR_W-1:0] addr_u1 = ADDR_W'(base_reg + ADDR_W'(ADDR_UNLOCK1));
	wire [ADDR_W-1:0] addr_u2 = ADDR_W'(base_reg + ADDR_W'(ADDR_UNLOCK2));
	wire [DATA_W-1:0] op_data = (op_reg == CMD_ENTER) ? DATA_W'(DATA_ENTER)
		: (op_reg == CMD_EXIT) ? DATA_W'(DATA_EXIT) : DATA_W'(DATA_PROGRAM);
	wire [ADDR_W-1:0] seq_addr = (step_reg == 2'd3) ? addr_reg
		: (step_reg == 2'd1) ? addr_u2 : addr_u1;
	wire [DATA_W-1:0] seq_data = (step_reg == 2'd3) ? wdata_reg
		: (step_reg == 2'd1) ? DATA_W'(DATA_UNLOCK2)
		: (step_reg == 2'd0) ? DATA_W'(DATA_UNLOCK1) : op_data;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_done ? cnt_reg : 16'(cnt_reg - 16'h0001);
		op_next = op_reg;
		step_next = step_reg;
		rdata_next = rdata_reg;
		prev_next = prev_reg;
		region_next = region_reg;
		lost_next = lost_reg;
		refused_next = refused_reg;
		timeout_next = timeout_reg;
		polling_next = polling_reg;
		first_next = first_reg;
		poll_cnt_next = poll_cnt_reg;
		ce_n_next = ce_n_reg;
		oe_n_next = oe_n_reg;
		we_n_next = we_n_reg;
		rst_n_next = rst_n_reg;
		dq_oe_next = dq_oe_reg;
		fl_addr_next = fl_addr_reg;
		fl_dq_next = fl_dq_reg;
		unique case (state_reg)
			S_RST_LOW: begin
				// Write strobe stays high so no command can land during reset
				if (cnt_done) begin
					rst_n_next = 1'b1;
					cnt_next = 16'(RESET_TO_CE_CYC);
					state_next = S_RST_GAP;
				end
			end
			S_RST_GAP: begin
				if (cnt_done) state_next = S_IDLE;
			end
			S_IDLE: begin
				if (cmd_go && refuse) refused_next = 1'b1;
				else if (cmd_go && (cmd_code == CMD_RESET)) begin
					rst_n_next = 1'b0;
					cnt_next = 16'(RESET_PULSE_CYC);
					lost_next = lost_reg || region_reg;
					region_next = 1'b0;
					state_next = S_RST_LOW;
				end else if (cmd_go && (cmd_code == CMD_READ)) begin
					fl_addr_next = addr_reg;
					ce_n_next = 1'b0;
					oe_n_next = 1'b0;
					polling_next = 1'b0;
					cnt_next = 16'(ACCESS_CYC);
					state_next = S_RD_ACC;
				end else if (cmd_go) begin
					op_next = cmd_code;
					step_next = 2'd0;
					cnt_next = 16'(ADDR_SETUP_CYC);
					state_next = S_WR_SETUP;
				end
			end
			S_WR_SETUP: begin
				// Address and data settle before the strobe falls
				fl_addr_next = seq_addr;
				fl_dq_next = seq_data;
				dq_oe_next = 1'b1;
				ce_n_next = 1'b0;
				if (cnt_done) begin
					we_n_next = 1'b0;
					cnt_next = 16'(WE_LOW_CYC);
					state_next = S_WR_LOW;
				end
			end
			S_WR_LOW: begin
				if (cnt_done) begin
					we_n_next = 1'b1;
					cnt_next = 16'(WE_HIGH_CYC);
					state_next = S_WR_HIGH;
				end
			end
			S_WR_HIGH: begin
				if (cnt_done && (step_reg != last_step)) begin
					step_next = 2'(step_reg + 2'd1);
					cnt_next = 16'(ADDR_SETUP_CYC);
					state_next = S_WR_SETUP;
				end else if (cnt_done) begin
					ce_n_next = 1'b1;
					dq_oe_next = 1'b0;
					if (op_reg == CMD_ENTER) region_next = 1'b1;
					if (op_reg == CMD_EXIT) region_next = 1'b0;
					if (op_reg == CMD_PROGRAM) begin
						// Embedded program runs on; poll its toggle bit before leaving
						fl_addr_next = addr_reg;
						polling_next = 1'b1;
						first_next = 1'b1;
						poll_cnt_next = 12'h000;
						cnt_next = 16'(BUS_GAP_CYC);
						state_next = S_RD_GAP;
					end else begin
						state_next = S_IDLE;
					end
				end
			end
			S_RD_ACC: begin
				if (cnt_done) begin
					rdata_next = dq_sync;
					prev_next = dq_sync;
					first_next = 1'b0;
					ce_n_next = 1'b1;
					oe_n_next = 1'b1;
					cnt_next = 16'(BUS_GAP_CYC);
					state_next = S_RD_GAP;
					// Two equal toggle bits in a row mean the embedded program ended
					if (polling_reg && !first_reg && toggle_same) polling_next = 1'b0;
					else if (poll_expire) begin
						polling_next = 1'b0;
						timeout_next = 1'b1;
					end else if (polling_reg) poll_cnt_next = 12'(poll_cnt_reg + 12'h001);
				end
			end
			S_RD_GAP: begin
				if (cnt_done && polling_reg) begin
					ce_n_next = 1'b0;
					oe_n_next = 1'b0;
					cnt_next = 16'(ACCESS_CYC);
					state_next = S_RD_ACC;
				end else if (cnt_done) state_next = S_IDLE;
			end
		endcase
		// Sticky flags: a clear loses to a set in the same cycle
		if (REG_WR && (REG_ADDR == REG_STATUS)) begin
			refused_next = refused_next && !(REG_WDATA[ST_REFUSED] && !(cmd_go && refuse));
			lost_next = lost_next && !(REG_WDATA[ST_MODE_LOST] && (lost_next == lost_reg));
			timeout_next = timeout_next && !(REG_WDATA[ST_TIMEOUT] && !poll_expire);
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= S_RST_LOW;
			cnt_reg <= 16'(RESET_PULSE_CYC);
			op_reg <= 4'h0;
			step_reg <= 2'd0;
			rdata_reg <= '0;
			prev_reg <= '0;
			region_reg <= 1'b0;
			lost_reg <= 1'b0;
			refused_reg <= 1'b0;
			timeout_reg <= 1'b0;
			polling_reg <= 1'b0;
			first_reg <= 1'b0;
			poll_cnt_reg <= 12'h000;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			op_reg <= op_next;
			step_reg <= step_next;
			rdata_reg <= rdata_next;
			prev_reg <= prev_next;
			region_reg <= region_next;
			lost_reg <= lost_next;
			refused_reg <= refused_next;
			timeout_reg <= timeout_next;
			polling_reg <= polling_next;
			first_reg <= first_next;
			poll_cnt_reg <= poll_cnt_next;
		end
	end

	// Pin flops; reset pin low and write strobe high from reset onward
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ce_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			rst_n_reg <= 1'b0;
			dq_oe_reg <= 1'b0;
			fl_addr_reg <= '0;
			fl_dq_reg <= '0;
		end else begin
			ce_n_reg <= ce_n_next;
			oe_n_reg <= oe_n_next;
			we_n_reg <= we_n_next;
			rst_n_reg <= rst_n_next;
			dq_oe_reg <= dq_oe_next;
			fl_addr_reg <= fl_addr_next;
			fl_dq_reg <= fl_dq_next;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	wire [31:0] status_word = {27'h0, timeout_reg, lost_reg, refused_reg, region_reg, !idle};
	wire [31:0] lock_word = {24'h0, 1'b1, customer_locked_reg, 6'(customer_locked_reg)};
	wire [31:0] rd_mux = (REG_ADDR == otprc_pkg::REG_ADDR) ? 32'(addr_reg)
		: (REG_ADDR == otprc_pkg::REG_WDATA) ? 32'(wdata_reg)
		: (REG_ADDR == REG_BASE) ? 32'(base_reg)
		: (REG_ADDR == REG_STATUS) ? status_word
		: (REG_ADDR == otprc_pkg::REG_RDATA) ? 32'(rdata_reg)
		: (REG_ADDR == REG_CFG) ? lock_word : 32'h0000_0000;

	// Operands are not guarded while busy; software changes them only when idle
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			addr_reg <= '0;
			wdata_reg <= '0;
			base_reg <= '0;
			customer_locked_reg <= 1'b0;
			reg_rdata_reg <= 32'h0000_0000;
		end else begin
			if (REG_WR && (REG_ADDR == otprc_pkg::REG_ADDR)) addr_reg <= REG_WDATA[ADDR_W-1:0];
			if (REG_WR && (REG_ADDR == otprc_pkg::REG_WDATA)) wdata_reg <= REG_WDATA[DATA_W-1:0];
			if (REG_WR && (REG_ADDR == REG_BASE)) base_reg <= REG_WDATA[ADDR_W-1:0];
			// Once set the lock flag sticks until controller reset
			if (REG_WR && (REG_ADDR == REG_CFG) && REG_WDATA[0]) customer_locked_reg <= 1'b1;
			if (REG_RD) reg_rdata_reg <= rd_mux;
		end
	end

	assign REG_RDATA = reg_rdata_reg;
	assign FL_CE_N = ce_n_reg;
	assign FL_OE_N = oe_n_reg;
	assign FL_WE_N = we_n_reg;
	assign FL_RESET_N = rst_n_reg;
	assign FL_FAST_PROGRAM_MODE = 1'b0;
	assign FL_ADDR = fl_addr_reg;
	assign FL_DQ_OUT = fl_dq_reg;
	assign FL_DQ_OE = dq_oe_reg;

endmodule // otprc_host
`default_nettype wire

// *** common/otprc_pkg.sv ***
`default_nettype none
package otprc_pkg;

	// ----------------------------------------
	// Timing; figures in ns, except SYNC_STAGES and the derived cycle counts
	// ----------------------------------------
	localparam int CLK_NS = 4;
	localparam int RESET_PULSE_MIN_TIME_NS = 500;
	localparam int RESET_TO_CE_NS = 200;
	localparam int ADDR_SETUP_NS = 8;
	localparam int WE_LOW_NS = 40;
	localparam int WE_HIGH_NS = 30;
	localparam int ADDRESS_ACCESS_TIME_NS = 70;
	localparam int SLEEP_MARGIN_NS = 20;
	localparam int BUS_GAP_NS = 20;
	localparam int SYNC_STAGES = 3;

	// Least times round up to whole cycles
	localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESET_TO_CE_CYC = (RESET_TO_CE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACCESS_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
	localparam int SLEEP_CYC = (ADDRESS_ACCESS_TIME_NS + SLEEP_MARGIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUS_GAP_CYC = (BUS_GAP_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------
	// Command cycles on the flash bus
	// ----------------------------------------
	localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
	localparam logic [11:0] ADDR_UNLOCK2 = 12'h2AA;
	localparam logic [15:0] DATA_UNLOCK1 = 16'h00AA;
	localparam logic [15:0] DATA_UNLOCK2 = 16'h0055;
	localparam logic [15:0] DATA_ENTER = 16'h0088;
	localparam logic [15:0] DATA_EXIT = 16'h0090;
	localparam logic [15:0] DATA_PROGRAM = 16'h00A0;
	localparam int TOGGLE_BIT = 6;

	// Identification region layout, word addresses
	localparam logic [15:0] CUSTOMER_FIRST = 16'h0080;
	localparam logic [15:0] REGION_WORDS = 16'h0100;

	// ----------------------------------------
	// Controller registers, byte offsets
	// ----------------------------------------
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_BASE = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RDATA = 8'h14;
	localparam logic [7:0] REG_CFG = 8'h18;

	localparam logic [3:0] CMD_ENTER = 4'h1;
	localparam logic [3:0] CMD_EXIT = 4'h2;
	localparam logic [3:0] CMD_PROGRAM = 4'h3;
	localparam logic [3:0] CMD_READ = 4'h4;
	localparam logic [3:0] CMD_RESET = 4'h5;

	localparam int ST_BUSY = 0;
	localparam int ST_REGION = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_MODE_LOST = 3;
	localparam int ST_TIMEOUT = 4;

	typedef enum logic [2:0] {
		S_RST_LOW,
		S_RST_GAP,
		S_IDLE,
		S_WR_SETUP,
		S_WR_LOW,
		S_WR_HIGH,
		S_RD_ACC,
		S_RD_GAP
	} otprc_state_t;

endpackage
`default_nettype wire

// *** design/otprc_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module otprc_sync #(
	parameter int W = 16
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [W-1:0] D_IN,
	output logic [W-1:0] Q
);
	import otprc_pkg::*;

	// ----------------------------------------
	// Per-bit three-stage synchroniser
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg, s2_reg, s3_reg, q_reg;
			// Stage one feeds stage two only; a change counts once stages two and three agree
			always_ff @(posedge MCLK or negedge RST_N) begin
				if (!RST_N) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					q_reg <= 1'b0;
				end else begin
					s1_reg <= D_IN[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						q_reg <= s3_reg;
					end
				end
			end
			assign Q[i] = q_reg;
		end
	endgenerate

endmodule // otprc_sync
`default_nettype wire

// *** sim/otprc_host_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module otprc_host_properties #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic FL_CE_N,
	input wire logic FL_OE_N,
	input wire logic FL_WE_N,
	input wire logic FL_RESET_N,
	input wire logic FL_FAST_PROGRAM_MODE,
	input wire logic [ADDR_W-1:0] FL_ADDR,
	input wire logic [DATA_W-1:0] FL_DQ_OUT,
	input wire logic FL_DQ_OE
);
	import otprc_pkg::*;
	logic [7:0] low_cnt_reg;
	logic [7:0] high_cnt_reg;
	logic [7:0] oe_cnt_reg;

	// Saturating run lengths; 8 bits is enough as every bound checked is below 255
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			low_cnt_reg <= 8'h00;
			high_cnt_reg <= 8'h00;
			oe_cnt_reg <= 8'h00;
		end else begin
			low_cnt_reg <= FL_RESET_N ? 8'h00 : low_cnt_reg + {7'h00, low_cnt_reg != 8'hFF};
			high_cnt_reg <= !FL_RESET_N ? 8'h00 : high_cnt_reg + {7'h00, high_cnt_reg != 8'hFF};
			oe_cnt_reg <= FL_OE_N ? 8'h00 : oe_cnt_reg + {7'h00, oe_cnt_reg != 8'hFF};
		end
	end

	// ----------------------------------------
	// Flash pin sequencing
	// ----------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_we_fall;
		$fell(FL_WE_N);
	endsequence
	sequence s_we_held;
		(!FL_WE_N && !FL_CE_N && FL_DQ_OE)[*8];
	endsequence
	sequence s_rd_fall;
		$fell(FL_OE_N);
	endsequence

	a_pulse_long: assert property ($rose(FL_RESET_N) |-> low_cnt_reg >= RESET_PULSE_CYC)
		else $error("flash reset pulse too short");
	a_reset_quiet: assert property (!FL_RESET_N |-> FL_WE_N && FL_CE_N && !FL_DQ_OE)
		else $error("bus active during flash reset");
	a_select_late: assert property (!FL_CE_N |-> high_cnt_reg >= RESET_TO_CE_CYC)
		else $error("chip select too soon after reset");
	a_no_fight: assert property (FL_DQ_OE |-> FL_OE_N)
		else $error("data driven while flash outputs enabled");
	a_fast_off: assert property (!FL_FAST_PROGRAM_MODE)
		else $error("accelerated programming requested");
	a_write_pulse: assert property (s_we_fall |-> s_we_held)
		else $error("write pulse short or unqualified");
	a_write_setup: assert property (s_we_fall |-> !$past(FL_CE_N) && $stable(FL_ADDR))
		else $error("address not set up before write");
	a_write_stable: assert property (!FL_WE_N && !$past(FL_WE_N) |->
		$stable(FL_ADDR) && $stable(FL_DQ_OUT))
		else $error("address or data moved in write pulse");
	a_read_wait: assert property ($rose(FL_OE_N) |-> oe_cnt_reg >= ACCESS_CYC - 1)
		else $error("read ended before access time");
	a_read_steady: assert property (s_rd_fall |=> (!FL_CE_N && FL_WE_N && $stable(FL_ADDR))[*8])
		else $error("read not held selected and steady");
	a_idle_float: assert property (FL_CE_N |-> FL_OE_N && !FL_DQ_OE)
		else $error("bus active while deselected");
endmodule // otprc_host_properties

bind otprc_host otprc_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
	.MCLK(MCLK), .RST_N(RST_N), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
	.FL_RESET_N(FL_RESET_N), .FL_FAST_PROGRAM_MODE(FL_FAST_PROGRAM_MODE),
	.FL_ADDR(FL_ADDR), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE)
);
`default_nettype wire

// *** sim/otprc_flash_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module otprc_flash_model #(
	parameter logic [23:0] FIRST_SECTOR_WORDS = 24'h008000,
	parameter logic [23:0] BASE = 24'h000000
) (
	input wire logic CE_N,
	input wire logic OE_N,
	input wire logic WE_N,
	input wire logic RESET_N,
	input wire logic [23:0] ADDR,
	input wire logic [15:0] DQ_IN,
	input wire logic DQ_OE,
	output logic [15:0] DQ_OUT
);
	logic [15:0] mem [0:255];
	logic [1:0] step = 2'h0;
	logic region = 1'b0;
	logic prog = 1'b0;
	logic [1:0] busy = 2'h0;
	logic tog = 1'b0;
	logic poll_rd = 1'b0;
	logic [15:0] last = 16'h0000;
	logic [15:0] val;
	wire logic drive = !CE_N && !OE_N && RESET_N;

	// Factory words carry a pattern, customer words start erased
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = (i < 128) ? (16'(i) ^ 16'hC3C3) : 16'hFFFF;
	end

	// Command decoder; floating data lines (no host drive) never form a command
	always @(posedge WE_N or negedge RESET_N) begin
		if (!RESET_N) begin
			step = 2'h0;
			region = 1'b0;
			prog = 1'b0;
			busy = 2'h0;
		end else if (!CE_N && DQ_OE) begin
			if (prog) begin
				if (region && ADDR >= 24'h80 && ADDR < 24'h100) mem[ADDR[7:0]] &= DQ_IN;
				busy = 2'h3;
				prog = 1'b0;
			end else if (step == 2'h0) step = (ADDR == BASE + 24'h555 && DQ_IN == 16'h00AA) ? 2'h1 : 2'h0;
			else if (step == 2'h1) step = (ADDR == BASE + 24'h2AA && DQ_IN == 16'h0055) ? 2'h2 : 2'h0;
			else begin
				step = 2'h0;
				if (ADDR == BASE + 24'h555 && DQ_IN == 16'h0088) region = 1'b1;
				if (ADDR == BASE + 24'h555 && DQ_IN == 16'h0090) region = 1'b0;
				if (ADDR == BASE + 24'h555 && DQ_IN == 16'h00A0) prog = 1'b1;
			end
		end
	end

	// Program runs on while deselected; each read during it shows toggling status
	// Chip select and output enable switch in one time step; look once both have settled
	always @(negedge OE_N) begin
		#1;
		poll_rd = !CE_N && busy != 2'h0;
		if (poll_rd) begin
			tog = ~tog;
			busy = busy - 2'h1;
		end
	end

	// Region overlays the first sector only; the rest stays array
	assign val = poll_rd ? {9'h000, tog, 6'h00} : (region && ADDR < FIRST_SECTOR_WORDS) ?
		(ADDR < 24'h100 ? mem[ADDR[7:0]] : ~ADDR[15:0]) : ADDR[15:0] ^ 16'h5A5A;

	// Released lines show the inverse of the last word, never a kind constant
	always @(*) if (drive) last = val;
	assign DQ_OUT = drive ? val : ~last;
endmodule // otprc_flash_model
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import otprc_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	wire logic [31:0] reg_rdata;
	wire logic fl_ce_n;
	wire logic fl_oe_n;
	wire logic fl_we_n;
	wire logic fl_reset_n;
	wire logic [23:0] fl_addr;
	wire logic [15:0] fl_dq_out;
	wire logic fl_dq_oe;
	wire logic [15:0] fl_dq_in;
	int fails = 0;
	int compares = 0;

	otprc_host #(.POLL_MAX(12'h008)) u_otprc_host (.MCLK(mclk), .RST_N(rst_n),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .FL_CE_N(fl_ce_n), .FL_OE_N(fl_oe_n), .FL_WE_N(fl_we_n),
		.FL_RESET_N(fl_reset_n), .FL_FAST_PROGRAM_MODE(), .FL_ADDR(fl_addr),
		.FL_DQ_OUT(fl_dq_out), .FL_DQ_OE(fl_dq_oe), .FL_DQ_IN(fl_dq_in));
	otprc_flash_model u_otprc_flash_model (.CE_N(fl_ce_n), .OE_N(fl_oe_n), .WE_N(fl_we_n),
		.RESET_N(fl_reset_n), .ADDR(fl_addr), .DQ_IN(fl_dq_out), .DQ_OE(fl_dq_oe),
		.DQ_OUT(fl_dq_in));

	// Clock at 250 MHz
	initial forever #2 mclk = ~mclk;

	// ----------------------------------------
	// Bus and comparison helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Busy is polled, never waited out by a fixed count
	task automatic wait_idle;
		logic [31:0] s;
		s = 32'h1;
		for (int n = 0; n < 400 && s[ST_BUSY] !== 1'b0; n++) rd(REG_STATUS, s);
		if (s[ST_BUSY] !== 1'b0) chk("busy wait", s, 32'h0);
	endtask
	task automatic run(input logic [3:0] code);
		wr(REG_CMD, {28'h0, code});
		wait_idle;
	endtask
	// Status check also clears the sticky bits for the next scenario
	task automatic st_chk(input logic [4:0] exp, input string what);
		logic [31:0] s;
		rd(REG_STATUS, s);
		chk(what, {27'h0, s[4:0]}, {27'h0, exp});
		wr(REG_STATUS, 32'h1C);
	endtask
	task automatic fl_read(input logic [23:0] a, input logic [15:0] exp, input string what);
		logic [31:0] d;
		wr(REG_ADDR, {8'h0, a});
		run(CMD_READ);
		rd(REG_RDATA, d);
		chk(what, {16'h0, d[15:0]}, {16'h0, exp});
	endtask
	task automatic prog(input logic [23:0] a, input logic [15:0] d);
		wr(REG_ADDR, {8'h0, a});
		wr(REG_WDATA, {16'h0, d});
		run(CMD_PROGRAM);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_power_up;
		logic [31:0] d;
		chk("reset pin in reset", {31'h0, fl_reset_n}, 32'h0);
		chk("write strobe in reset", {31'h0, fl_we_n}, 32'h1);
		@(posedge mclk);
		rst_n <= 1'b1;
		wait_idle;
		st_chk(5'h00, "status after reset");
		wr(REG_BASE, 32'h0);
		fl_read(24'h000010, 16'h0010 ^ 16'h5A5A, "array read");
		rd(8'h40, d);
		chk("unmapped offset", d, 32'h0);
		run(4'h7);
		st_chk(5'h04, "unknown code");
	endtask
	task automatic t_enter;
		run(CMD_ENTER);
		st_chk(5'h02, "region entered");
		fl_read(24'h000005, 16'h0005 ^ 16'hC3C3, "factory word");
		fl_read(24'h009000, 16'h9000 ^ 16'h5A5A, "outside first sector");
		wr(REG_ADDR, 32'h200);
		run(CMD_READ);
		st_chk(5'h06, "beyond region");
	endtask
	task automatic t_program;
		logic [31:0] d;
		rd(REG_CFG, d);
		chk("lock flags open", d, 32'h80);
		prog(24'h000085, 16'h1234);
		st_chk(5'h02, "customer program");
		fl_read(24'h000085, 16'h1234, "customer word");
		prog(24'h000010, 16'h0000);
		st_chk(5'h06, "factory program");
		fl_read(24'h000010, 16'h0010 ^ 16'hC3C3, "factory kept");
		wr(REG_CFG, 32'h1);
		rd(REG_CFG, d);
		chk("lock flags shut", d, 32'hC1);
		prog(24'h000086, 16'h0000);
		st_chk(5'h06, "locked program");
		fl_read(24'h000086, 16'hFFFF, "customer kept");
	endtask
	task automatic t_exit;
		run(CMD_EXIT);
		st_chk(5'h00, "region left");
		fl_read(24'h000085, 16'h0085 ^ 16'h5A5A, "first sector array");
	endtask
	task automatic t_hw_reset;
		run(CMD_ENTER);
		run(CMD_RESET);
		st_chk(5'h08, "mode lost");
		fl_read(24'h000005, 16'h0005 ^ 16'h5A5A, "array after reset");
	endtask

	task automatic wrap_up;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Main sequence: reset held 20 cycles, then the scenarios in order
	initial begin
		repeat (20) @(posedge mclk);
		t_power_up;
		t_enter;
		t_program;
		t_exit;
		t_hw_reset;
		wrap_up;
	end

	// Watchdog well beyond the expected run of about 1200 cycles
	initial begin
		repeat (30000) @(posedge mclk);
		fails++;
		wrap_up;
	end
endmodule // tb_top
`default_nettype wire
